// ---- bench/flash_dev_model.sv ----
// behavioural nor flash device seen from the host pins
`timescale 1ns/1ns
module flash_dev_model #(
  parameter logic [15:0] IDENT_CODE = 16'h5a5a, // arbitrary value
  parameter int          ACC_NS     = 70,
  parameter int          PROG_NS    = 200,
  parameter int          READY_NS   = 570
) (
  input  wire logic [21:0] addr,
  input  wire logic [15:0] line_dq,
  input  wire logic        chip_sel_n,
  input  wire logic        out_gate_n,
  input  wire logic        write_strobe_n,
  input  wire logic        flash_reset_n,
  input  wire logic        protect_boost_pin,
  input  wire logic        program_boost_level,
  input  wire logic        hold_busy,
  output logic [15:0]      dev_dq,
  output logic             done_or_working_flag,
  output logic             seq_err
);
  logic [15:0] mem [int];
  logic [15:0] rd_now;
  logic [15:0] rd;
  logic [15:0] last = 16'hffff;
  logic [2:0]  seq = 3'h0;
  logic        ident = 1'b0;
  logic        drive;
  logic        drv_late;
  int          busy_ns = 0;
  int          wr_cnt = 0;
  int          last_wa = 0;
  initial seq_err = 1'b0;
  // boost is its own digital input, logic cannot sense voltage
  wire boost = program_boost_level;
  // reads are served while a program runs; no bank stalls here
  assign drive = !chip_sel_n && !out_gate_n && flash_reset_n;
  assign #ACC_NS drv_late = drive;
  always @(addr, ident, wr_cnt) begin
    if (ident) rd_now = IDENT_CODE;
    else if (mem.exists(int'(addr))) rd_now = mem[int'(addr)];
    else rd_now = 16'hffff;
  end
  // output stays latched while the address is stable
  assign #ACC_NS rd = rd_now;
  always @(rd, drive, drv_late) if (drive && drv_late) last = rd;
  // a released bus shows the inverse, never the last value
  assign dev_dq = (drive && drv_late) ? rd : ~last;
  // work goes on whether or not the chip stays selected
  always #10 if (busy_ns > 0) busy_ns = busy_ns - 10;
  assign done_or_working_flag = (busy_ns == 0) && !hold_busy;
  always @(negedge flash_reset_n) begin
    seq = 3'h0;
    ident = 1'b0;
    // idle reset ends inside the pulse, so the flag stays high
    if (busy_ns > 0) begin
      // a cut-short program leaves its word unwritten
      mem.delete(last_wa);
      wr_cnt++;
      busy_ns = READY_NS;
    end
  end
  task automatic step(input logic ok, input logic [2:0] nxt);
    if (ok) seq = nxt;
    else begin
      seq_err = 1'b1;
      seq = 3'h0;
    end
  endtask
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && flash_reset_n) begin
      if (boost && seq == 3'h0) step(line_dq == 16'h00a0, 3'h3);
      else begin
        case (seq)
          3'h0: step(addr == 22'h00_0555 && line_dq == 16'h00aa, 3'h1);
          3'h1: step(addr == 22'h00_02aa && line_dq == 16'h0055, 3'h2);
          3'h2: begin
            if (line_dq == 16'h0090) begin
              ident = 1'b1;
              seq = 3'h0;
            end else step(addr == 22'h00_0555 && line_dq == 16'h00a0, 3'h3);
          end
          default: begin
            // lowest sector is locked unless pin high or boost
            if (boost || protect_boost_pin || addr[21:12] != 10'h000)
              mem[int'(addr)] = line_dq;
            last_wa = int'(addr);
            wr_cnt++;
            busy_ns = PROG_NS;
            seq = 3'h0;
          end
        endcase
      end
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the parallel flash host controller
`timescale 1ns/1ns
module tb_top;
  import flash_host_pkg::*;
  localparam logic [15:0] IDENT_CODE = 16'h5a5a; // arbitrary value
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  op_t         req_op = OP_READ;
  logic [21:0] req_addr = 22'h00_0000;
  logic [15:0] req_data = 16'h0000;
  logic        boost_req = 1'b0;
  logic        protect_release = 1'b1;
  logic        hold_busy = 1'b0;
  logic        req_ready, resp_valid, resp_error, op_boot_sector;
  logic [15:0] resp_data, dq_out, dev_dq, line_dq, r_data;
  logic [7:0]  op_sector;
  logic [21:0] flash_addr;
  logic        dq_oe, chip_sel_n, out_gate_n, write_strobe_n;
  logic        flash_reset_n, protect_boost_pin, program_boost_level;
  logic        done_or_working_flag, seq_err, r_err;
  int          n_mismatch = 0;
  int          n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  assign line_dq = dq_oe ? dq_out : dev_dq;
  flash_host_ctrl #(.READY_WAIT(20)) dut (
    .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .boost_req(boost_req),
    .protect_release(protect_release), .resp_valid(resp_valid),
    .resp_error(resp_error), .resp_data(resp_data),
    .op_sector(op_sector), .op_boot_sector(op_boot_sector),
    .flash_addr(flash_addr), .dq_in(line_dq), .dq_out(dq_out),
    .dq_oe(dq_oe), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
    .write_strobe_n(write_strobe_n), .flash_reset_n(flash_reset_n),
    .protect_boost_pin(protect_boost_pin),
    .program_boost_level(program_boost_level),
    .done_or_working_flag(done_or_working_flag));
  flash_dev_model #(.IDENT_CODE(IDENT_CODE)) flash (
    .addr(flash_addr), .line_dq(line_dq), .chip_sel_n(chip_sel_n),
    .out_gate_n(out_gate_n), .write_strobe_n(write_strobe_n),
    .flash_reset_n(flash_reset_n), .protect_boost_pin(protect_boost_pin),
    .program_boost_level(program_boost_level), .hold_busy(hold_busy),
    .dev_dq(dev_dq), .done_or_working_flag(done_or_working_flag),
    .seq_err(seq_err));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_val(input logic [21:0] got, input logic [21:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val(22'(got), 22'(exp));
  endtask
  // inputs move 1 ns after the edge; response bounded by a count
  task automatic do_req(input op_t op, input logic [21:0] a,
                        input logic [15:0] d);
    int n;
    n = 0;
    req_op = op;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    while (resp_valid !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk_bit(resp_valid, 1'b1);
    r_data = resp_data;
    r_err = resp_error;
  endtask
  task automatic rd_chk(input logic [21:0] a, input logic [15:0] exp);
    do_req(OP_READ, a, 16'h0000);
    chk_val(22'(r_data), 22'(exp));
  endtask
  task automatic t_read_map;
    rd_chk(22'h00_3000, 16'hffff);
    chk_val(22'(op_sector), 22'h00_0003);
    chk_bit(op_boot_sector, 1'b1);
    rd_chk(22'h3f_ffff, 16'hffff);
    chk_val(22'(op_sector), 22'h00_0086);
    chk_bit(op_boot_sector, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk_bit(chip_sel_n, 1'b1);
    chk_bit(flash_reset_n, 1'b1);
    chk_bit(out_gate_n, 1'b1);
    chk_bit(dq_oe, 1'b0);
    $display("test read_map done");
  endtask
  task automatic t_program;
    do_req(OP_PROG, 22'h00_8000, 16'h5a3c);
    rd_chk(22'h00_8000, 16'h5a3c);
    chk_val(22'(op_sector), 22'h00_0008);
    chk_bit(op_boot_sector, 1'b0);
    $display("test program done");
  endtask
  task automatic t_boost;
    protect_release = 1'b0;
    boost_req = 1'b1;
    do_req(OP_PROG, 22'h00_0010, 16'h1111);
    chk_bit(program_boost_level, 1'b1);
    chk_bit(protect_boost_pin, 1'b1);
    boost_req = 1'b0;
    rd_chk(22'h00_0010, 16'h1111);
    chk_bit(program_boost_level, 1'b0);
    chk_bit(protect_boost_pin, 1'b0);
    do_req(OP_PROG, 22'h00_0020, 16'h2222);
    rd_chk(22'h00_0020, 16'hffff);
    protect_release = 1'b1;
    $display("test boost done");
  endtask
  task automatic t_ident;
    do_req(OP_IDENT, 22'h00_0000, 16'h0000);
    rd_chk(22'h00_8000, IDENT_CODE);
    do_req(OP_RESET, 22'h00_0000, 16'h0000);
    chk_bit(r_err, 1'b0);
    rd_chk(22'h00_8000, 16'h5a3c);
    $display("test ident done");
  endtask
  task automatic t_reset;
    do_req(OP_PROG, 22'h00_8001, 16'h0f0f);
    do_req(OP_RESET, 22'h00_0000, 16'h0000);
    chk_bit(r_err, 1'b0);
    rd_chk(22'h00_8001, 16'hffff);
    do_req(OP_PROG, 22'h00_8001, 16'h0f0f);
    rd_chk(22'h00_8001, 16'h0f0f);
    // a flag that never rises must end as an error
    hold_busy = 1'b1;
    do_req(OP_RESET, 22'h00_0000, 16'h0000);
    chk_bit(r_err, 1'b1);
    hold_busy = 1'b0;
    chk_bit(seq_err, 1'b0);
    $display("test reset done");
  endtask
  initial begin
    #100_000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_read_map();
    t_program();
    t_boost();
    t_ident();
    t_reset();
    report_and_stop();
  end
endmodule

// ---- core/flash_host_ctrl.sv ----
// host controller driving an asynchronous parallel nor flash by its pins
// Overview of operation
// RL1: boost level on protect pin makes device fast-program and unprotect.
// RL2: with boost applied, host programs using the two-write sequence.
// RL3: removing boost returns the device to normal protection and commands.
// RL4: identification command makes reads return internal codes on 16 lines.
// RL5: reads from one bank proceed while another bank programs or erases.
// RL6: suspended erase allows access elsewhere in bank except that sector.
// RL7: chip select and reset both high put device in standby, outputs off.
// RL8: host waits full chip-select access time before sampling read data.
// RL9: deselecting during program or erase lets the operation complete.
// RL10: stable address for access time plus 30 ns enters sleep.
// RL11: address change in sleep gives data within address access time.
// RL12: reset pulse of minimum width aborts, tristates, returns to reading.
// RL13: host reissues an operation that a reset cut short.
// RL14: reset during program or erase holds busy flag low until done.
// RL15: reset while idle completes within the shorter recovery time.
// RL16: host waits reset-high gap after releasing reset before reading.
// RL17: output gate high disables device outputs to high impedance.
// RL18: upper address bits select eight boot sectors then large sectors.
// RL19: fast mode programs with two write cycles instead of four.
// RL20: host reads with chip select and output gate low, strobe high.
// RL21: boost level is a separate digital signal beside high and low.
`timescale 1ns/1ns
`include "flash_host_defines.svh"
module flash_host_ctrl #(
  parameter int unsigned READY_WAIT = `READY_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire flash_host_pkg::op_t   req_op,
  input  wire logic [21:0]           req_addr,
  input  wire logic [15:0]           req_data,
  input  wire logic                  boost_req,
  input  wire logic                  protect_release,
  output logic                       resp_valid,
  output logic                       resp_error,
  output logic [15:0]                resp_data,
  output logic [7:0]                 op_sector,
  output logic                       op_boot_sector,
  output logic [21:0]                flash_addr,
  input  wire logic [15:0]           dq_in,
  output logic [15:0]                dq_out,
  output logic                       dq_oe,
  output logic                       chip_sel_n,
  output logic                       out_gate_n,
  output logic                       write_strobe_n,
  output logic                       flash_reset_n,
  output logic                       protect_boost_pin,
  output logic                       program_boost_level,
  input  wire logic                  done_or_working_flag
);
  import flash_host_pkg::*;

  localparam logic [15:0] READ_LAST  = 16'(`ACCESS_CYC + `SYNC_CYC - 1);
  localparam logic [15:0] WLOW_LAST  = 16'(`WR_LOW_CYC - 1);
  localparam logic [15:0] WHIGH_LAST = 16'(`WR_HIGH_CYC - 1);
  localparam logic [15:0] RLOW_LAST  = 16'(`RESET_LOW_CYC - 1);
  localparam logic [15:0] RGAP_LAST  = 16'(`RESET_GAP_CYC - 1);
  localparam logic [15:0] POLL_LAST  = 16'(READY_WAIT - 1);

  host_t st;
  host_t next_st;
  // one write cycle of a command sequence: {address, data}
  function automatic logic [37:0] cmd_word(input op_t op, input logic fast,
                                          input logic [2:0] step,
                                          input logic [21:0] a,
                                          input logic [15:0] d);
    logic [37:0] w;
    w = {a, d};
    if (op == OP_PROG && fast) begin
      w = (step == 3'h0) ? {a, `PROGRAM_DATA} : {a, d}; // RL2 RL19
    end else begin
      case (step)
        3'h0: w = {`UNLOCK_ADDR1, `UNLOCK_DATA1};
        3'h1: w = {`UNLOCK_ADDR2, `UNLOCK_DATA2};
        3'h2: w = {`UNLOCK_ADDR1,
                   (op == OP_IDENT) ? `IDENT_DATA : `PROGRAM_DATA}; // RL4
        default: w = {a, d};
      endcase
    end
    return w;
  endfunction
  function automatic logic [2:0] last_step(input op_t op, input logic fast);
    if (op == OP_IDENT) begin
      return `IDENT_STEPS;
    end
    return fast ? `FAST_PROG_STEPS : `STD_PROG_STEPS; // RL19
  endfunction
  always_comb begin
    next_st = st;
    next_st.resp_v    = 1'b0;
    next_st.busy_meta = done_or_working_flag;
    next_st.busy_sync = st.busy_meta;
    next_st.dq_meta   = dq_in;
    next_st.dq_sync   = st.dq_meta;
    next_st.cnt       = st.cnt + 16'h0001;
    case (st.state)
      S_IDLE: begin
        // boost only moves between operations so no sequence straddles it
        next_st.boost   = boost_req; // RL1 RL3 RL21
        next_st.wp_high = protect_release | boost_req;
        next_st.ce_n    = 1'b1; // RL7
        next_st.oe_n    = 1'b1;
        next_st.we_n    = 1'b1;
        next_st.dq_oe   = 1'b0;
        next_st.cnt     = 16'h0000;
        next_st.step    = 3'h0;
        if (req_valid) begin
          next_st.op    = req_op;
          next_st.addr  = req_addr;
          next_st.wdata = req_data;
          case (req_op)
            OP_READ: begin
              next_st.pin_addr = req_addr;
              next_st.ce_n     = 1'b0; // RL20
              next_st.oe_n     = 1'b0;
              next_st.state    = S_READ;
            end
            OP_RESET: begin
              next_st.rp_n  = 1'b0; // RL12
              next_st.state = S_RLOW;
            end
            default: begin
              {next_st.pin_addr, next_st.dq_out} =
                cmd_word(req_op, boost_req, 3'h0, req_addr, req_data);
              next_st.dq_oe = 1'b1;
              next_st.ce_n  = 1'b0;
              next_st.state = S_WSET;
            end
          endcase
        end
      end
      S_READ: begin
        if (st.cnt == READ_LAST) begin
          next_st.rdata    = st.dq_sync; // RL8
          next_st.resp_v   = 1'b1;
          next_st.resp_err = 1'b0;
          next_st.ce_n     = 1'b1;
          next_st.oe_n     = 1'b1;
          next_st.state    = S_IDLE;
        end
      end
      S_WSET: begin
        next_st.we_n  = 1'b0;
        next_st.cnt   = 16'h0000;
        next_st.state = S_WLOW;
      end
      S_WLOW: begin
        if (st.cnt == WLOW_LAST) begin
          next_st.we_n  = 1'b1;
          next_st.cnt   = 16'h0000;
          next_st.state = S_WHIGH;
        end
      end
      S_WHIGH: begin
        if (st.cnt == WHIGH_LAST) begin
          next_st.cnt = 16'h0000;
          if (st.step == last_step(st.op, st.boost)) begin
            // device finishes on its own once deselected
            next_st.ce_n     = 1'b1; // RL9
            next_st.dq_oe    = 1'b0;
            next_st.resp_v   = 1'b1;
            next_st.resp_err = 1'b0;
            next_st.state    = S_IDLE;
          end else begin
            next_st.step = st.step + 3'h1;
            {next_st.pin_addr, next_st.dq_out} =
              cmd_word(st.op, st.boost, st.step + 3'h1, st.addr, st.wdata);
            next_st.state = S_WSET;
          end
        end
      end
      S_RLOW: begin
        if (st.cnt == RLOW_LAST) begin
          next_st.rp_n  = 1'b1; // RL12
          next_st.cnt   = 16'h0000;
          next_st.state = S_RGAP;
        end
      end
      S_RGAP: begin
        if (st.cnt == RGAP_LAST) begin
          next_st.cnt   = 16'h0000; // RL16
          next_st.state = S_RPOLL;
        end
      end
      S_RPOLL: begin
        // busy low means internal reset still running
        if (st.busy_sync || st.cnt == POLL_LAST) begin
          next_st.resp_v   = 1'b1; // RL13 RL14 RL15
          next_st.resp_err = ~st.busy_sync;
          next_st.state    = S_IDLE;
        end
      end
      default: begin
        next_st.state = S_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st         <= '0;
      st.state   <= S_IDLE;
      st.op      <= OP_READ;
      st.ce_n    <= 1'b1;
      st.oe_n    <= 1'b1;
      st.we_n    <= 1'b1;
      st.rp_n    <= 1'b1;
      st.wp_high <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  sector_map u_sector (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .word_addr    (st.addr),
    .sector_index (op_sector),
    .boot_sector  (op_boot_sector)
  );
  assign req_ready           = (st.state == S_IDLE);
  assign resp_valid          = st.resp_v;
  assign resp_error          = st.resp_err;
  assign resp_data           = st.rdata;
  assign flash_addr          = st.pin_addr;
  assign dq_out              = st.dq_out;
  assign dq_oe               = st.dq_oe;
  assign chip_sel_n          = st.ce_n;
  assign out_gate_n          = st.oe_n;
  assign write_strobe_n      = st.we_n;
  assign flash_reset_n       = st.rp_n;
  assign protect_boost_pin   = st.wp_high;
  assign program_boost_level = st.boost;
  // helper counters seen only by the checks below
  logic [15:0] oe_low_cnt, rp_low_cnt, rp_high_cnt;
  logic [2:0]  wr_pulses;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oe_low_cnt  <= 16'h0000;
      rp_low_cnt  <= 16'h0000;
      rp_high_cnt <= 16'hffff;
      wr_pulses   <= 3'h0;
    end else begin
      oe_low_cnt  <= out_gate_n ? 16'h0000 : oe_low_cnt + 16'h0001;
      rp_low_cnt  <= flash_reset_n ? 16'h0000 : rp_low_cnt + 16'h0001;
      if (!flash_reset_n) begin
        rp_high_cnt <= 16'h0000;
      end else if (rp_high_cnt != 16'hffff) begin
        rp_high_cnt <= rp_high_cnt + 16'h0001;
      end
      if (st.state == S_IDLE) begin
        wr_pulses <= 3'h0;
      end else if ($fell(write_strobe_n)) begin
        wr_pulses <= wr_pulses + 3'h1;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence read_done_s;
    resp_valid && st.op == OP_READ;
  endsequence
  idle_standby_a: assert property ( // RL7
    req_ready |-> chip_sel_n && flash_reset_n && !dq_oe)
    else $error("idle without standby pins");
  read_strobes_a: assert property ( // RL20
    st.state == S_READ |-> !chip_sel_n && !out_gate_n && write_strobe_n)
    else $error("read strobes wrong");
  read_wait_a: assert property ( // RL8
    read_done_s |-> $past(oe_low_cnt) >= 16'(`ACCESS_CYC + `SYNC_CYC - 1))
    else $error("read data sampled early");
  no_contend_a: assert property ( // RL17
    !out_gate_n |-> !dq_oe && write_strobe_n)
    else $error("host drives bus while output gate low");
  reset_width_a: assert property ( // RL12
    $rose(flash_reset_n) |-> $past(rp_low_cnt) == RLOW_LAST)
    else $error("reset pulse width wrong");
  reset_gap_a: assert property ( // RL16
    $fell(out_gate_n) |-> rp_high_cnt >= 16'(`RESET_GAP_CYC))
    else $error("read too soon after reset release");
  boost_stable_a: assert property ( // RL3
    $changed(program_boost_level) |-> $past(st.state) == S_IDLE)
    else $error("boost changed mid operation");
  prog_count_a: assert property ( // RL2
    resp_valid && st.op == OP_PROG |->
      wr_pulses == (program_boost_level ? 3'h2 : 3'h4))
    else $error("program sequence length wrong");
  ident_count_a: assert property ( // RL4
    resp_valid && st.op == OP_IDENT |-> wr_pulses == 3'h3)
    else $error("identification sequence length wrong");
  reset_busy_a: assert property ( // RL14
    resp_valid && st.op == OP_RESET && !resp_error |-> $past(st.busy_sync))
    else $error("reset reported done while busy");
  release_ce_a: assert property ( // RL9
    resp_valid && st.op == OP_PROG |-> chip_sel_n && !dq_oe && req_ready)
    else $error("chip select held after program");
endmodule

// ---- core/flash_host_defines.svh ----
// timing counts and command words for the parallel flash host
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

`define CLK_NS          4
`define T_ACCESS_NS     70
`define T_CHIPSEL_NS    70
`define T_RESET_LOW_NS  500
`define T_RESET_GAP_NS  50
`define T_WR_LOW_NS     35
`define T_WR_HIGH_NS    20
`define T_READY_NS      20000

`define ACCESS_CYC  ((((`T_ACCESS_NS > `T_CHIPSEL_NS) ? `T_ACCESS_NS : `T_CHIPSEL_NS) + `CLK_NS - 1) / `CLK_NS)
`define SYNC_CYC    2
`define RESET_LOW_CYC  ((`T_RESET_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define RESET_GAP_CYC  ((`T_RESET_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define WR_LOW_CYC     ((`T_WR_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define WR_HIGH_CYC    ((`T_WR_HIGH_NS + `CLK_NS - 1) / `CLK_NS)
`define READY_CYC      (`T_READY_NS / `CLK_NS)

`define UNLOCK_ADDR1   22'h00_0555
`define UNLOCK_ADDR2   22'h00_02aa
`define UNLOCK_DATA1   16'h00aa
`define UNLOCK_DATA2   16'h0055
`define PROGRAM_DATA   16'h00a0
`define IDENT_DATA     16'h0090

`define STD_PROG_STEPS   3'h3
`define FAST_PROG_STEPS  3'h1
`define IDENT_STEPS      3'h2

`define BOOT_SECTORS     8'h08
`endif

// ---- core/flash_host_pkg.sv ----
// types shared by the parallel flash host
package flash_host_pkg;
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_PROG  = 2'h1,
    OP_IDENT = 2'h2,
    OP_RESET = 2'h3
  } op_t;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_READ  = 8'h02,
    S_WSET  = 8'h04,
    S_WLOW  = 8'h08,
    S_WHIGH = 8'h10,
    S_RLOW  = 8'h20,
    S_RGAP  = 8'h40,
    S_RPOLL = 8'h80
  } state_t;

  typedef struct packed {
    state_t      state;
    op_t         op;
    logic [2:0]  step;
    logic [15:0] cnt;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic        boost;
    logic        wp_high;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        rp_n;
    logic        dq_oe;
    logic [15:0] dq_out;
    logic [21:0] pin_addr;
    logic        resp_v;
    logic        resp_err;
    logic [15:0] rdata;
    logic        busy_meta;
    logic        busy_sync;
    logic [15:0] dq_meta;
    logic [15:0] dq_sync;
  } host_t;

  typedef struct packed {
    logic [7:0] index;
    logic       boot;
  } sector_t;
endpackage

// ---- core/sector_map.sv ----
// sector index of a word address
`timescale 1ns/1ns
`include "flash_host_defines.svh"
module sector_map (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [21:0] word_addr,
  output logic [7:0]       sector_index,
  output logic             boot_sector
);
  import flash_host_pkg::*;
  sector_t st;
  sector_t next_st;
  logic [6:0] big;

  always_comb begin
    big = word_addr[21:15];
    next_st = st;
    if (big == 7'h00) begin
      next_st.index = {5'h00, word_addr[14:12]}; // RL18
      next_st.boot  = 1'b1;
    end else begin
      next_st.index = {1'b0, big} + `BOOT_SECTORS - 8'h01; // RL18
      next_st.boot  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sector_index = st.index;
  assign boot_sector  = st.boot;
endmodule
